// ==== hw/ifsl_link.sv ====
// Isolated fast serial link engine, device side
//
// Summary of operation
// - Four wires: clock, out, in, clear-to-send
// - Serial mode moves second channel pins to link
// - Mode 10 holds reset; 0 releases it
// - Mode comes from configuration memory straps
// - Frame starts with low start bit
// - No outbound start during inbound frame
// - Outbound data shifts least significant first
// - Last outbound bit names source channel
// - Start bit drops clear-to-send next rising edge
// - Capture eight data bits, least significant first
// - Last inbound bit selects destination channel
// - Disabled destination redirects to other channel
// - No channel enabled disables the link
// - Clear-to-send low until byte accepted
`timescale 1ns/100ps
`include "ifsl_params.svh"
module ifsl_link
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_chan_a_serial_i,
  input wire logic cfg_chan_b_serial_i,
  input wire logic mode_write_i,
  input wire ifsl_pkg::ifsl_byte_type mode_value_i,
  output logic link_held_o,
  output logic link_active_o,
  output logic chan_b_pins_link_o,
  input wire logic tx_a_valid_i,
  input wire ifsl_pkg::ifsl_byte_type tx_a_data_i,
  output logic tx_a_ready_o,
  input wire logic tx_b_valid_i,
  input wire ifsl_pkg::ifsl_byte_type tx_b_data_i,
  output logic tx_b_ready_o,
  output logic rx_a_valid_o,
  output logic rx_b_valid_o,
  output ifsl_pkg::ifsl_byte_type rx_data_o,
  input wire logic rx_a_ready_i,
  input wire logic rx_b_ready_i,
  input wire logic link_clock_in_i,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic inbound_clear_to_send_o
);
  import ifsl_pkg::*;

  // ****************************************************************
  // Configuration and pin synchronisation
  // ****************************************************************
  logic cfg_a_q;
  logic cfg_b_q;
  logic cfg_loaded_q;
  logic hold_q;
  logic link_enable;
  logic deliver_b;
  logic clk_level;
  logic clk_rise;
  logic clk_fall;
  logic din_level;
  logic rx_destination_channel_bit_q;

  // Straps are caught once after reset release
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_a_q <= 1'b0;
      cfg_b_q <= 1'b0;
      cfg_loaded_q <= 1'b0;
    end
    else if (!cfg_loaded_q)
    begin
      cfg_a_q <= cfg_chan_a_serial_i;
      cfg_b_q <= cfg_chan_b_serial_i;
      cfg_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_q <= 1'b0;
    end
    else if (mode_write_i)
    begin
      if (mode_value_i == `IFSL_MODE_RESET_HOLD)
      begin
        hold_q <= 1'b1;
      end
      else if (mode_value_i == `IFSL_MODE_RELEASE)
      begin
        hold_q <= 1'b0;
      end
    end
  end

  ifsl_sync u_clk_sync
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(link_clock_in_i),
    .level_o(clk_level),
    .rise_o(clk_rise),
    .fall_o(clk_fall)
  );

  ifsl_sync u_din_sync
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(serial_in_line_i),
    .level_o(din_level),
    .rise_o(),
    .fall_o()
  );

  ifsl_route u_route
  (
    .chan_a_serial_i(cfg_a_q),
    .chan_b_serial_i(cfg_b_q),
    .destination_channel_bit_bit_i(rx_destination_channel_bit_q),
    .link_enable_o(link_enable),
    .deliver_b_o(deliver_b)
  );

  assign link_held_o = hold_q;
  assign link_active_o = link_enable && !hold_q;
  assign chan_b_pins_link_o = link_enable;

  // ****************************************************************
  // Inbound receiver
  // ****************************************************************
  ifsl_rx_state_type rx_state_q;
  logic [3:0] rx_count_q;
  ifsl_byte_type rx_shift_q;
  logic cts_q;
  logic rx_busy;

  // Inbound data is taken on rising edges of the link clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_state_q <= IFSL_RX_IDLE;
      rx_count_q <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_destination_channel_bit_q <= 1'b0;
      cts_q <= 1'b0;
    end
    else if (!link_enable)
    begin
      rx_state_q <= IFSL_RX_IDLE;
      cts_q <= 1'b0;
    end
    else
    begin
      case (rx_state_q)
        IFSL_RX_IDLE:
        begin
          cts_q <= 1'b1;
          if (clk_rise && cts_q && din_level == `IFSL_START_VALUE)
          begin
            rx_state_q <= IFSL_RX_SHIFT;
            rx_count_q <= 4'h0;
            cts_q <= 1'b0;
          end
        end
        IFSL_RX_SHIFT:
        begin
          if (clk_rise)
          begin
            if (rx_count_q == 4'(`IFSL_DATA_BITS))
            begin
              rx_destination_channel_bit_q <= din_level;
              rx_state_q <= IFSL_RX_HOLD;
            end
            else
            begin
              rx_shift_q <= {din_level, rx_shift_q[7:1]};
              rx_count_q <= rx_count_q + 4'h1;
            end
          end
        end
        IFSL_RX_HOLD:
        begin
          if ((deliver_b && rx_b_ready_i) || (!deliver_b && rx_a_ready_i))
          begin
            rx_state_q <= IFSL_RX_IDLE;
          end
        end
        default:
        begin
          rx_state_q <= IFSL_RX_IDLE;
        end
      endcase
    end
  end

  assign rx_busy = rx_state_q == IFSL_RX_SHIFT;
  assign rx_data_o = rx_shift_q;
  assign rx_a_valid_o = (rx_state_q == IFSL_RX_HOLD) && !deliver_b;
  assign rx_b_valid_o = (rx_state_q == IFSL_RX_HOLD) && deliver_b;
  assign inbound_clear_to_send_o = cts_q;

  // ****************************************************************
  // Outbound transmitter
  // ****************************************************************
  ifsl_tx_state_type tx_state_q;
  logic [3:0] tx_count_q;
  logic [9:0] tx_frame_q;
  logic tx_out_q;
  logic tx_take;
  logic tx_pick_b;

  // Second channel is served first when both wait
  assign tx_pick_b = tx_b_valid_i;
  assign tx_take = (tx_state_q == IFSL_TX_IDLE) && link_active_o && clk_fall
    && !rx_busy && (tx_a_valid_i || tx_b_valid_i);
  assign tx_b_ready_o = tx_take && tx_pick_b;
  assign tx_a_ready_o = tx_take && !tx_pick_b;

  // Outbound bits change on falling edges so the far end samples on rise
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_state_q <= IFSL_TX_IDLE;
      tx_count_q <= 4'h0;
      tx_frame_q <= 10'h3ff;
      tx_out_q <= `IFSL_IDLE_VALUE;
    end
    else
    begin
      case (tx_state_q)
        IFSL_TX_IDLE:
        begin
          tx_out_q <= `IFSL_IDLE_VALUE;
          if (tx_take)
          begin
            tx_frame_q <= tx_pick_b
              ? {`IFSL_CHAN_SECOND, tx_b_data_i, `IFSL_START_VALUE}
              : {`IFSL_CHAN_FIRST, tx_a_data_i, `IFSL_START_VALUE};
            tx_out_q <= `IFSL_START_VALUE;
            tx_count_q <= 4'h1;
            tx_state_q <= IFSL_TX_SHIFT;
          end
        end
        IFSL_TX_SHIFT:
        begin
          if (clk_fall)
          begin
            tx_out_q <= tx_frame_q[tx_count_q];
            if (tx_count_q == 4'(`IFSL_FRAME_BITS - 1))
            begin
              tx_state_q <= IFSL_TX_DONE;
            end
            else
            begin
              tx_count_q <= tx_count_q + 4'h1;
            end
          end
        end
        IFSL_TX_DONE:
        begin
          if (clk_fall)
          begin
            tx_out_q <= `IFSL_IDLE_VALUE;
            tx_state_q <= IFSL_TX_IDLE;
          end
        end
        default:
        begin
          tx_state_q <= IFSL_TX_IDLE;
        end
      endcase
    end
  end

  assign serial_out_line_o = tx_out_q;

endmodule

// ==== hw/ifsl_route.sv ====
// Channel enable resolution and inbound destination steering
`timescale 1ns/100ps
`include "ifsl_params.svh"
module ifsl_route
(
  input wire logic chan_a_serial_i,
  input wire logic chan_b_serial_i,
  input wire logic destination_channel_bit_bit_i,
  output logic link_enable_o,
  output logic deliver_b_o
);
  import ifsl_pkg::*;

  always_comb
  begin
    link_enable_o = chan_a_serial_i || chan_b_serial_i;
    if (destination_channel_bit_bit_i == `IFSL_CHAN_SECOND)
    begin
      deliver_b_o = chan_b_serial_i;
    end
    else
    begin
      deliver_b_o = !chan_a_serial_i;
    end
  end
endmodule

// ==== hw/ifsl_sync.sv ====
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/100ps
module ifsl_sync
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import ifsl_pkg::*;

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic [1:0] fill_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edges count only once the chain holds real pin samples
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fill_q <= 2'h0;
    end
    else if (fill_q != 2'h3)
    begin
      fill_q <= fill_q + 2'h1;
    end
  end

  assign level_o = sync_q;
  assign rise_o = (fill_q == 2'h3) && sync_q && !last_q;
  assign fall_o = (fill_q == 2'h3) && !sync_q && last_q;
endmodule

// ==== shared/ifsl_params.svh ====
// Timing counts, field positions and reset values of the isolated serial link
`ifndef IFSL_PARAMS_SVH
`define IFSL_PARAMS_SVH

`define IFSL_DATA_BITS 8
`define IFSL_FRAME_BITS 10
`define IFSL_START_VALUE 1'b0
`define IFSL_IDLE_VALUE 1'b1
`define IFSL_CHAN_FIRST 1'b0
`define IFSL_CHAN_SECOND 1'b1
`define IFSL_MODE_RESET_HOLD 8'h10
`define IFSL_MODE_RELEASE 8'h00
`define IFSL_SYNC_STAGES 2

`endif

// ==== shared/ifsl_pkg.sv ====
// Types shared by the isolated serial link design
package ifsl_pkg;

  typedef logic [7:0] ifsl_byte_type;

  typedef enum logic [1:0]
  {
    IFSL_TX_IDLE = 2'b00,
    IFSL_TX_SHIFT = 2'b01,
    IFSL_TX_DONE = 2'b10
  } ifsl_tx_state_type;

  typedef enum logic [1:0]
  {
    IFSL_RX_IDLE = 2'b00,
    IFSL_RX_SHIFT = 2'b01,
    IFSL_RX_HOLD = 2'b10
  } ifsl_rx_state_type;

endpackage

// ==== testbench/ifsl_far_end.sv ====
// Far-end model: clocks the link and trades frames with the engine
`timescale 1ns/100ps
module ifsl_far_end
(
  output logic clk_o = 1'b0,
  output logic data_o = 1'b1,
  input wire logic data_i,
  input wire logic cts_i
);
  task automatic send(input logic [8:0] bits);
    while (!cts_i) #40;
    for (int i = 0; i < 10; i++)
    begin
      data_o = i ? bits[i-1] : 1'b0;
      #160 clk_o = 1'b1;
      #160 clk_o = 1'b0;
    end
    data_o = 1'b1;
  endtask
  task automatic recv(input int stall, output logic [9:0] f);
    int n;
    f = 10'h3ff;
    n = 0;
    for (int k = 0; k < 40 && n < 10; k++)
    begin
      #160 clk_o = 1'b1;
      if (n > 0 || !data_i)
      begin
        f[n] = data_i;
        n++;
      end
      if (n == 1)
        #(stall);
      #160 clk_o = 1'b0;
    end
  endtask
endmodule

// ==== testbench/ifsl_link_asserts.sv ====
// Port checks for the serial link engine
`timescale 1ns/100ps
module ifsl_link_asserts
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_held_o,
  input wire logic chan_b_pins_link_o,
  input wire logic tx_a_ready_o,
  input wire logic tx_b_ready_o,
  input wire logic rx_a_valid_o,
  input wire logic rx_b_valid_o,
  input wire logic rx_a_ready_i,
  input wire logic rx_b_ready_i,
  input wire logic serial_out_line_o,
  input wire logic inbound_clear_to_send_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic tk = tx_a_ready_o || tx_b_ready_o;
  wire logic cts = inbound_clear_to_send_o;
  sequence start_s;
    !serial_out_line_o [*7];
  endsequence
  start_bit_a: assert property
    (tk |=> start_s) else $error("short start");
  held_quiet_a: assert property
    (link_held_o |-> !tk) else $error("sent held");
  off_quiet_a: assert property
    (!chan_b_pins_link_o |-> !tk) else $error("sent off");
  off_cts_a: assert property
    (!chan_b_pins_link_o |-> !cts) else $error("cts off");
  busy_cts_a: assert property
    (rx_a_valid_o || rx_b_valid_o |-> !cts) else $error("cts busy");
  one_destination_channel_bit_a: assert property
    (!(rx_a_valid_o && rx_b_valid_o)) else $error("two dests");
  keep_a_a: assert property
    (rx_a_valid_o && !rx_a_ready_i |=> rx_a_valid_o) else $error("a lost");
  keep_b_a: assert property
    (rx_b_valid_o && !rx_b_ready_i |=> rx_b_valid_o) else $error("b lost");
  ready_back_a: assert property
    ($fell(rx_a_valid_o || rx_b_valid_o) |-> ##[1:2] cts)
    else $error("cts stuck");
endmodule

// ==== testbench/test_ifsl_link.sv ====
// Self-checking bench for the serial link engine
`timescale 1ns/100ps
`include "ifsl_params.svh"
module test_ifsl_link;
  import ifsl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mw = 1'b0;
  logic [1:0] cfg = 2'b11, tv = 2'b00, rr = 2'b00;
  ifsl_byte_type mv = 8'h00, td = 8'h00;
  wire ifsl_byte_type rd;
  wire logic [1:0] tr, rv;
  wire logic held, pins, act, lclk, sin, sout, cts;
  int mismatches = 0, total_checks = 0;
  ifsl_link i_dut
  (
    .clk_i(clk), .rst_n_i(rst_n), .cfg_chan_a_serial_i(cfg[0]),
    .cfg_chan_b_serial_i(cfg[1]), .mode_write_i(mw), .mode_value_i(mv),
    .link_held_o(held), .link_active_o(act), .chan_b_pins_link_o(pins),
    .tx_a_valid_i(tv[0]), .tx_a_data_i(td), .tx_a_ready_o(tr[0]),
    .tx_b_valid_i(tv[1]), .tx_b_data_i(td), .tx_b_ready_o(tr[1]),
    .rx_a_valid_o(rv[0]), .rx_b_valid_o(rv[1]), .rx_data_o(rd),
    .rx_a_ready_i(rr[0]), .rx_b_ready_i(rr[1]), .link_clock_in_i(lclk),
    .serial_in_line_i(sin), .serial_out_line_o(sout),
    .inbound_clear_to_send_o(cts)
  );
  ifsl_far_end far
  (
    .clk_o(lclk), .data_o(sin), .data_i(sout), .cts_i(cts)
  );
  initial forever #20 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: %h", $time, s);
    end
  endtask
  task automatic wrap_up;
    $display("%0d checks, %0d wrong", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic mode(input ifsl_byte_type v);
    mv = v;
    mw = 1'b1;
    step(1);
    mw = 1'b0;
    step(1);
  endtask
  task automatic tx_one(input logic ch, input logic on);
    logic [9:0] got;
    td = 8'($urandom);
    tv[ch] = 1'b1;
    fork
      far.recv($urandom % 300, got);
      begin
        step(1);
        for (int i = 0; i < 700 && !tr[ch]; i++)
          step(1);
        step(1);
        tv[ch] = 1'b0;
      end
    join
    step(5);
    chk(got, on ? {ch, td, 1'b0} : 10'h3ff);
    chk(10'(sout), 10'h001);
  endtask
  task automatic rx_one(input logic destination_channel_bit);
    td = 8'($urandom);
    far.send({destination_channel_bit, td});
    for (int i = 0; i < 50 && rv === 2'b00; i++)
      step(1);
    chk(10'(rv), (destination_channel_bit ? cfg[1] : !cfg[0]) ? 10'h002 : 10'h001);
    chk(10'(rd), 10'(td));
    chk(10'(cts), 10'h000);
    rr = rv;
    step(1);
    rr = 2'b00;
    step(3);
    chk(10'(cts), 10'h001);
  endtask
  initial
  begin
    void'($urandom(13));
    for (int c = 3; c >= 0; c--)
    begin
      rst_n = 1'b0;
      cfg = 2'(c);
      step(5);
      rst_n = 1'b1;
      step(3);
      chk(10'(pins), 10'(c != 0));
      chk(10'(act), 10'(c != 0));
      for (int k = 0; k < 4; k++)
      begin
        tx_one(1'(k), c != 0);
        if (c != 0)
          rx_one(1'($urandom));
      end
      if (c == 1)
      begin
        mode(`IFSL_MODE_RESET_HOLD);
        chk(10'(held), 10'h001);
        chk(10'(act), 10'h000);
        mode(8'($urandom) | 8'h01);
        chk(10'(held), 10'h001);
        tx_one(1'b1, 1'b0);
        mode(`IFSL_MODE_RELEASE);
        chk(10'(held), 10'h000);
        tx_one(1'b0, 1'b1);
      end
      $display("setting %0d done", c);
    end
    wrap_up;
  end
  initial
  begin
    #2_000_000 mismatches++;
    wrap_up;
  end
endmodule
bind ifsl_link ifsl_link_asserts i_chk (.*);
